/* tcc_timer.sv */
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - Force strobes act only in non-PWM wave modes; ignored in PWM modes.
// - A force strobe makes an immediate match on the waveform output.
// - A forced match sets no flag, raises no interrupt, never clears counter.
// - Force strobe bits always read back as zero.
// - Control B bits 5 and 4 are reserved and read zero.
// - Clock select: stop, undivided, then divide by 8,32,64,128,256,1024.
// - Counter register is directly readable and writable, eight bits.
// - A counter write suppresses compare matches on the next timer tick.
// - Both compare registers are compared with the counter continuously.
// - Compare irq enables at mask bits 2 and 1, gated by global enable.
// - Overflow irq enable at mask bit 0, gated by global enable and flag.
// - Flag bit 2 sets when counter matches compare B.
// - Flag bit 1 sets when counter matches compare A.
// - Flag bit 0 sets when the counter overflows.
// - In phase-correct PWM overflow flag sets on direction change at zero.
// - A flag clears when its interrupt vector is executed.
// - Writing one clears a flag; writing zero leaves it.
// - Wave mode selects normal, phase PWM, clear-on-match, fast PWM and tops.
// - Non-PWM out modes: disconnected, toggle, clear, set on match.
// - Prescaler source is the system clock or the oscillator pin clock.
module tcc_timer (
	input  wire logic                  mclk_i,
	input  wire logic                  reset_n_i,
	input  wire tcc_pkg::tcc_apb_req_s apb_i,
	input  wire logic                  tosc_clk_i,
	input  wire logic [2:0]            vector_ack_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	output logic [2:0]                 irq_o,
	output logic                       wave_out_a_o,
	output logic                       wave_out_b_o,
	output logic                       wave_en_a_o,
	output logic                       wave_en_b_o
);
	import tcc_pkg::*;

	// ----------------------------------------------------------------
	// Prescaler tap selection
	// ----------------------------------------------------------------
	function automatic logic presc_tick(input logic [2:0] sel,
		input logic [9:0] pre, input logic src);
		logic [9:0] m;
		m = DIV8_MASK;
		unique case (sel)
			3'h2: m = DIV8_MASK;
			3'h3: m = DIV32_MASK;
			3'h4: m = DIV64_MASK;
			3'h5: m = DIV128_MASK;
			3'h6: m = DIV256_MASK;
			3'h7: m = DIV1024_MASK;
			default: m = DIV8_MASK;
		endcase
		if (sel == 3'h0)
			return 1'b0;
		else if (sel == 3'h1)
			return src;
		else
			return src & ((pre & m) == m);
	endfunction : presc_tick

	// Next level of one waveform output
	function automatic logic wave_next(input logic cur,
		input logic [1:0] om, input logic [2:0] wm, input logic hit,
		input logic wrap, input logic down, input logic may_toggle);
		logic r;
		r = cur;
		if (!wm[0])
		begin
			if (hit)
				r = (om == 2'h1) ? ~cur : (om == 2'h2) ? 1'b0 :
					(om == 2'h3) ? 1'b1 : cur;
		end
		else if (om == 2'h1)
		begin
			if (hit && wm[2] && may_toggle)
				r = ~cur;
		end
		else if (om[1] && wm[1])
		begin
			if (wrap)
				r = ~om[0];
			else if (hit)
				r = om[0];
		end
		else if (om[1])
		begin
			if (hit)
				r = down ? ~om[0] : om[0];
		end
		return r;
	endfunction : wave_next

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] control_a;
	logic [3:0] control_b;      // wave_mode_msb and clock_prescale_sel
	logic [7:0] timer_count;
	logic [7:0] compare_value_a;
	logic [7:0] compare_value_b;
	logic [2:0] timer_irq_mask;
	logic [2:0] timer_irq_flags;
	logic [1:0] config_bits;
	logic [9:0] prescale;
	logic       count_down;
	logic       match_block;
	logic       tosc_meta;
	logic       tosc_sync;
	logic       tosc_prev;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire setup_phase = apb_i.psel & ~apb_i.penable;
	wire access_done = apb_i.psel & apb_i.penable & pready_o;
	wire wr_en       = access_done & apb_i.pwrite;
	wire [7:0] wdata = apb_i.pwdata[7:0];
	wire wr_ctrl_a   = wr_en & (apb_i.paddr == ADDR_CONTROL_A);
	wire wr_ctrl_b   = wr_en & (apb_i.paddr == ADDR_CONTROL_B);
	wire wr_count    = wr_en & (apb_i.paddr == ADDR_COUNT);
	wire wr_cmp_a    = wr_en & (apb_i.paddr == ADDR_CMP_A);
	wire wr_cmp_b    = wr_en & (apb_i.paddr == ADDR_CMP_B);
	wire wr_mask     = wr_en & (apb_i.paddr == ADDR_IRQ_MASK);
	wire wr_flags    = wr_en & (apb_i.paddr == ADDR_IRQ_FLAGS);
	wire wr_config   = wr_en & (apb_i.paddr == ADDR_CONFIG);
	wire addr_known  = (apb_i.paddr[1:0] == 2'h0) &&
		(apb_i.paddr <= ADDR_CONFIG);

	// Read mux; strobes and reserved bits come back as zero
	wire [7:0] read_byte =
		(apb_i.paddr == ADDR_CONTROL_A) ? control_a :
		(apb_i.paddr == ADDR_CONTROL_B) ? {4'h0, control_b} :
		(apb_i.paddr == ADDR_COUNT)     ? timer_count :
		(apb_i.paddr == ADDR_CMP_A)     ? compare_value_a :
		(apb_i.paddr == ADDR_CMP_B)     ? compare_value_b :
		(apb_i.paddr == ADDR_IRQ_MASK)  ? {5'h0, timer_irq_mask} :
		(apb_i.paddr == ADDR_IRQ_FLAGS) ? {5'h0, timer_irq_flags} :
		(apb_i.paddr == ADDR_CONFIG)    ? {6'h0, config_bits} :
		RESET_BYTE;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire [1:0] out_mode_a         = control_a[OUT_A_LSB +: 2];
	wire [1:0] out_mode_b         = control_a[OUT_B_LSB +: 2];
	wire [1:0] wave_mode_low_bits = control_a[1:0];
	wire       wave_mode_msb      = control_b[WAVE_MSB_BIT];
	wire [2:0] clock_prescale_sel = control_b[2:0];
	wire [2:0] wave_mode = {wave_mode_msb, wave_mode_low_bits};
	wire pwm_mode      = wave_mode[0];
	wire phase_mode    = (wave_mode[1:0] == 2'h1);
	wire top_is_cmp_a  = (wave_mode == 3'h2) | (wave_mode == 3'h5) |
		(wave_mode == 3'h7);
	wire [7:0] top_value = top_is_cmp_a ? compare_value_a : COUNT_MAX;
	wire async_clock_sel = config_bits[ASYNC_SEL_BIT];
	wire global_irq_en   = config_bits[GLOBAL_EN_BIT];

	// ----------------------------------------------------------------
	// Timer tick
	// ----------------------------------------------------------------
	// Oscillator pin is slow; only its rising edge after sync is used
	wire tosc_rise = tosc_sync & ~tosc_prev;
	wire timer_src_clock = async_clock_sel ? tosc_rise : 1'b1;
	wire tick = presc_tick(clock_prescale_sel, prescale,
		timer_src_clock);

	// ----------------------------------------------------------------
	// Compare and counting
	// ----------------------------------------------------------------
	wire at_top  = (timer_count == top_value);
	wire at_bot  = (timer_count == COUNT_BOT);
	wire match_a = tick & ~match_block &
		(timer_count == compare_value_a);
	wire match_b = tick & ~match_block &
		(timer_count == compare_value_b);
	wire wrap    = tick & at_top & ~phase_mode;
	wire ovf_evt = phase_mode ? (tick & count_down & at_bot) :
		(wave_mode == 3'h7) ? wrap :
		(tick & (timer_count == COUNT_MAX));
	// Forced compares feed only the waveform path
	wire force_a = wr_ctrl_b & wdata[FORCE_A_BIT] & ~pwm_mode;
	wire force_b = wr_ctrl_b & wdata[FORCE_B_BIT] & ~pwm_mode;

	logic [7:0] next_count;
	logic       next_down;
	always_comb
	begin
		next_count = timer_count;
		next_down  = count_down;
		if (tick)
		begin
			if (phase_mode)
			begin
				if (count_down && at_bot)
				begin
					next_count = timer_count + 8'h01;
					next_down  = 1'b0;
				end
				else if (count_down)
					next_count = timer_count - 8'h01;
				else if (at_top)
				begin
					next_count = timer_count - 8'h01;
					next_down  = 1'b1;
				end
				else
					next_count = timer_count + 8'h01;
			end
			else if (at_top && (wave_mode[1] || top_is_cmp_a))
				next_count = COUNT_BOT; // Match clears only from real ticks
			else
				next_count = timer_count + 8'h01;
		end
		if (wr_count)
			next_count = wdata;
	end

	// Flag update: hardware set wins over vector or W1C clear
	wire [2:0] flag_set = {match_b, match_a, ovf_evt};
	wire [2:0] flag_clr = vector_ack_i |
		(wr_flags ? wdata[2:0] : 3'h0);
	wire [2:0] next_flags = (timer_irq_flags & ~flag_clr) | flag_set;
	wire [2:0] irq_req = timer_irq_flags & timer_irq_mask &
		{3{global_irq_en}};

	wire next_wave_a = wave_next(wave_out_a_o, out_mode_a, wave_mode,
		match_a | force_a, wrap, count_down, 1'b1);
	wire next_wave_b = wave_next(wave_out_b_o, out_mode_b, wave_mode,
		match_b | force_b, wrap, count_down, 1'b0);

	// ----------------------------------------------------------------
	// Pin synchroniser and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tosc_meta <= 1'b0;
			tosc_sync <= 1'b0;
			tosc_prev <= 1'b0;
			prescale  <= 10'h000;
		end
		else
		begin
			tosc_meta <= tosc_clk_i;
			tosc_sync <= tosc_meta;
			tosc_prev <= tosc_sync;
			prescale  <= prescale + {9'h000, timer_src_clock};
		end
	end

	// ----------------------------------------------------------------
	// Registers written by software
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			control_a       <= RESET_BYTE;
			control_b       <= 4'h0;
			compare_value_a <= RESET_BYTE;
			compare_value_b <= RESET_BYTE;
			timer_irq_mask  <= 3'h0;
			config_bits     <= 2'h0;
		end
		else
		begin
			if (wr_ctrl_a)
				control_a <= {wdata[7:4], 2'h0, wdata[1:0]};
			if (wr_ctrl_b)
				control_b <= wdata[3:0];
			if (wr_cmp_a)
				compare_value_a <= wdata;
			if (wr_cmp_b)
				compare_value_b <= wdata;
			if (wr_mask)
				timer_irq_mask <= wdata[2:0];
			if (wr_config)
				config_bits <= wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Counter, flags and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			timer_count     <= RESET_BYTE;
			count_down      <= 1'b0;
			match_block     <= 1'b0;
			timer_irq_flags <= 3'h0;
			irq_o           <= 3'h0;
			wave_out_a_o    <= 1'b0;
			wave_out_b_o    <= 1'b0;
			wave_en_a_o     <= 1'b0;
			wave_en_b_o     <= 1'b0;
		end
		else
		begin
			timer_count     <= next_count;
			count_down      <= next_down;
			// Block holds until the next timer tick has gone by
			match_block     <= wr_count | (match_block & ~tick);
			timer_irq_flags <= next_flags;
			irq_o           <= irq_req;
			wave_out_a_o    <= next_wave_a;
			wave_out_b_o    <= next_wave_b;
			wave_en_a_o     <= (out_mode_a != 2'h0);
			wave_en_b_o     <= (out_mode_b != 2'h0);
		end
	end

	// ----------------------------------------------------------------
	// APB answer: read data caught in setup, ready on first access
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= setup_phase;
			if (setup_phase)
			begin
				prdata_o  <= {24'h000000, read_byte};
				pslverr_o <= ~addr_known;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	a_ctrl_b_reserved: assert property (
		(setup_phase && apb_i.paddr == ADDR_CONTROL_B) |=>
		prdata_o[7:4] == 4'h0)
		else $error("control_b high bits not zero");
	a_count_write_lands: assert property (
		wr_count |=> timer_count == $past(wdata))
		else $error("counter write lost");
	a_block_no_flag: assert property (
		(wr_count ##1 (tick && !vector_ack_i[1] && !wr_flags)) |=>
		timer_irq_flags[1] == $past(timer_irq_flags[1]))
		else $error("match not blocked after counter write");
	a_flag_a_sets: assert property (
		(tick && !match_block && timer_count == compare_value_a)
		|=> timer_irq_flags[IRQ_CMP_A_BIT])
		else $error("compare A flag missed");
	a_flag_b_sets: assert property (
		(tick && !match_block && timer_count == compare_value_b)
		|=> timer_irq_flags[IRQ_CMP_B_BIT])
		else $error("compare B flag missed");
	a_ovf_normal: assert property (
		(tick && wave_mode == 3'h0 && timer_count == COUNT_MAX)
		|=> timer_irq_flags[IRQ_OVF_BIT] && timer_count == COUNT_BOT)
		else $error("normal overflow missed");
	a_ovf_phase_bot: assert property (
		(tick && phase_mode && count_down && at_bot) |=>
		timer_irq_flags[IRQ_OVF_BIT] && !count_down)
		else $error("phase overflow at bottom missed");
	a_w1c_clears: assert property (
		(wr_flags && wdata[IRQ_OVF_BIT] && !ovf_evt) |=>
		!timer_irq_flags[IRQ_OVF_BIT])
		else $error("write one did not clear flag");
	a_vector_clears: assert property (
		(vector_ack_i[IRQ_CMP_A_BIT] && !match_a) |=>
		!timer_irq_flags[IRQ_CMP_A_BIT])
		else $error("vector did not clear flag");
	a_irq_gating: assert property (
		(timer_irq_flags[IRQ_CMP_B_BIT] && timer_irq_mask[IRQ_CMP_B_BIT]
		&& global_irq_en) ##1 !global_irq_en |->
		irq_o[IRQ_CMP_B_BIT] ##1 !irq_o[IRQ_CMP_B_BIT])
		else $error("interrupt gating wrong");
	a_force_toggles: assert property (
		(force_a && !match_a && out_mode_a == 2'h1) |=>
		wave_out_a_o != $past(wave_out_a_o))
		else $error("force did not toggle output");
	a_force_no_flag: assert property (
		(force_b && !match_b && !vector_ack_i[IRQ_CMP_B_BIT]) |=>
		timer_irq_flags[IRQ_CMP_B_BIT] == $past(timer_irq_flags[2]))
		else $error("force changed compare flag");
	a_pwm_force_inert: assert property (
		(wr_ctrl_b && wdata[FORCE_A_BIT] && pwm_mode && !tick) |=>
		$stable(wave_out_a_o))
		else $error("force acted in PWM mode");
	a_stopped_clock: assert property (
		(clock_prescale_sel == 3'h0 && !wr_count) |=>
		$stable(timer_count))
		else $error("counter ran while stopped");

	c_force_event: cover property (force_a ##1 wave_en_a_o);
	c_phase_ovf: cover property (tick && phase_mode && count_down && at_bot);
	c_block_hit: cover property (wr_count ##[1:20] (tick && match_block));
	c_irq_raise: cover property ($rose(irq_o[IRQ_OVF_BIT]));

endmodule : tcc_timer

/* tcc_pkg.sv */
package tcc_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses on the APB slave
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
	localparam logic [7:0] ADDR_COUNT     = 8'h08;
	localparam logic [7:0] ADDR_CMP_A     = 8'h0c;
	localparam logic [7:0] ADDR_CMP_B     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_CONFIG    = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FORCE_A_BIT   = 7;   // control_b
	localparam int FORCE_B_BIT   = 6;
	localparam int WAVE_MSB_BIT  = 3;
	localparam int OUT_A_LSB     = 6;   // control_a
	localparam int OUT_B_LSB     = 4;
	localparam int IRQ_CMP_B_BIT = 2;   // mask and flags
	localparam int IRQ_CMP_A_BIT = 1;
	localparam int IRQ_OVF_BIT   = 0;
	localparam int ASYNC_SEL_BIT = 0;   // config
	localparam int GLOBAL_EN_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values and fixed levels
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_MAX  = 8'hff;
	localparam logic [7:0] COUNT_BOT  = 8'h00;

	// Prescaler taps: divide by 8, 32, 64, 128, 256, 1024
	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV32_MASK   = 10'h01f;
	localparam logic [9:0] DIV64_MASK   = 10'h03f;
	localparam logic [9:0] DIV128_MASK  = 10'h07f;
	localparam logic [9:0] DIV256_MASK  = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK = 10'h3ff;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tcc_apb_req_s;

endpackage : tcc_pkg

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import tcc_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus, observed outputs and bookkeeping
	// ----------------------------------------------------------------
	logic         mclk_i;
	logic         reset_n_i;
	tcc_apb_req_s req;
	logic [2:0]   ack;
	logic         tosc;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic [2:0]   irq;
	logic         wa;
	logic         wb;
	logic         ea;
	logic         eb;
	logic [7:0]   rv;
	logic         err;
	int           n_errors;
	int           samples_checked;
	int           cycles;

	// Oscillator pin moves only in the async scenario
	tcc_timer uut (
		.mclk_i       (mclk_i),
		.reset_n_i    (reset_n_i),
		.apb_i        (req),
		.tosc_clk_i   (tosc),
		.vector_ack_i (ack),
		.prdata_o     (prdata),
		.pready_o     (pready),
		.pslverr_o    (pslverr),
		.irq_o        (irq),
		.wave_out_a_o (wa),
		.wave_out_b_o (wb),
		.wave_en_a_o  (ea),
		.wave_en_b_o  (eb)
	);

	// 100 MHz clock
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer; waits for pready with a bounded count
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(posedge mclk_i);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= a;
		req.pwdata  <= {24'h0, d};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check("pready_wait", 32'h0, 32'h1);
		rv = prdata[7:0];
		err = pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e,
		input string what);
		apb(1'b0, a, 8'h00);
		check(what, {24'h0, rv}, {24'h0, e});
	endtask : rdc

	task automatic pulse_ack(input logic [2:0] v);
		@(posedge mclk_i);
		ack <= v;
		@(posedge mclk_i);
		ack <= 3'b000;
	endtask : pulse_ack

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] regs [6];
		regs = '{ADDR_CONTROL_B, ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B,
			ADDR_IRQ_MASK, ADDR_IRQ_FLAGS};
		foreach (regs[i])
			rdc(regs[i], 8'h00, "reset_value");
		wr(ADDR_COUNT, 8'ha5);
		rdc(ADDR_COUNT, 8'ha5, "count_rw");
		wr(ADDR_CMP_B, 8'hc3);
		rdc(ADDR_CMP_B, 8'hc3, "cmp_b_rw");
		wr(ADDR_IRQ_MASK, 8'hff);
		rdc(ADDR_IRQ_MASK, 8'h07, "mask_rw");
		wr(ADDR_IRQ_MASK, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		check("unmapped_err", {31'h0, err}, 32'h1);
		wr(ADDR_CONTROL_B, 8'h30);
		rdc(ADDR_CONTROL_B, 8'h00, "reserved_bits");
		wr(ADDR_COUNT, 8'h5a);
		wr(ADDR_CMP_B, 8'h00);
	endtask : t_regs

	// Counter is stopped, so only forced matches move the outputs
	task automatic t_force;
		logic       pa;
		logic       pb;
		logic [2:0] mm;
		for (int m = 0; m < 8; m++)
		begin
			mm = m[2:0];
			pa = wa;
			pb = wb;
			wr(ADDR_CONTROL_A, {6'h14, mm[1:0]});
			wr(ADDR_CONTROL_B, {4'hc, mm[2], 3'b000});
			repeat (2) @(posedge mclk_i);
			check("force_a", {31'h0, wa}, {31'h0, mm[0] ? pa : ~pa});
			check("force_b", {31'h0, wb}, {31'h0, mm[0] ? pb : ~pb});
			rdc(ADDR_CONTROL_B, {4'h0, mm[2], 3'b000}, "ctl_b_rd");
		end
		check("wave_en", {30'h0, ea, eb}, 32'h3);
		wr(ADDR_CONTROL_B, 8'h00);
		for (int k = 3; k > 0; k--)
		begin
			wr(ADDR_CONTROL_A, {2'b00, k[1:0], 4'h0});
			wr(ADDR_CONTROL_B, 8'h40);
			repeat (2) @(posedge mclk_i);
			check("out_mode_b", {31'h0, wb}, (k == 2) ? 32'h0 : 32'h1);
		end
		rdc(ADDR_IRQ_FLAGS, 8'h00, "force_no_flag");
		rdc(ADDR_COUNT, 8'h5a, "force_no_clear");
		wr(ADDR_CONTROL_A, 8'h00);
		repeat (2) @(posedge mclk_i);
		check("wave_en_off", {30'h0, ea, eb}, 32'h0);
	endtask : t_force

	task automatic t_match;
		wr(ADDR_CMP_A, 8'h20);
		wr(ADDR_CMP_B, 8'h30);
		wr(ADDR_COUNT, 8'h10);
		wr(ADDR_IRQ_MASK, 8'h06);
		wr(ADDR_CONFIG, 8'h02);
		wr(ADDR_CONTROL_B, 8'h01);
		repeat (60) @(posedge mclk_i);
		rdc(ADDR_IRQ_FLAGS, 8'h06, "match_flags");
		check("irq_cmp", {29'h0, irq}, 32'h6);
		wr(ADDR_CONFIG, 8'h00);
		repeat (2) @(posedge mclk_i);
		check("irq_global_off", {29'h0, irq}, 32'h0);
		wr(ADDR_CONFIG, 8'h02);
		wr(ADDR_IRQ_MASK, 8'h02);
		repeat (2) @(posedge mclk_i);
		check("irq_masked", {29'h0, irq}, 32'h2);
		wr(ADDR_IRQ_FLAGS, 8'h00);
		rdc(ADDR_IRQ_FLAGS, 8'h06, "w0_keeps");
		wr(ADDR_IRQ_FLAGS, 8'h04);
		rdc(ADDR_IRQ_FLAGS, 8'h02, "w1_clears");
		pulse_ack(3'b010);
		rdc(ADDR_IRQ_FLAGS, 8'h00, "vector_clear");
		wr(ADDR_CONTROL_B, 8'h00);
	endtask : t_match

	task automatic t_overflow;
		wr(ADDR_COUNT, 8'hf0);
		wr(ADDR_IRQ_FLAGS, 8'h07);
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CONTROL_B, 8'h01);
		repeat (30) @(posedge mclk_i);
		apb(1'b0, ADDR_IRQ_FLAGS, 8'h00);
		check("ovf_flag", {31'h0, rv[0]}, 32'h1);
		check("ovf_irq", {31'h0, irq[0]}, 32'h1);
		wr(ADDR_CONFIG, 8'h00);
		repeat (2) @(posedge mclk_i);
		check("ovf_gate", {31'h0, irq[0]}, 32'h0);
		pulse_ack(3'b001);
		apb(1'b0, ADDR_IRQ_FLAGS, 8'h00);
		check("ovf_vec_clr", {31'h0, rv[0]}, 32'h0);
		// Counter write on a running counter: next match must be lost
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CMP_A, 8'h80);
		wr(ADDR_CMP_B, 8'h80);
		wr(ADDR_IRQ_FLAGS, 8'h07);
		wr(ADDR_COUNT, 8'h80);
		repeat (20) @(posedge mclk_i);
		apb(1'b0, ADDR_IRQ_FLAGS, 8'h00);
		check("write_blocks", {30'h0, rv[2:1]}, 32'h0);
		wr(ADDR_CONTROL_B, 8'h00);
	endtask : t_overflow

	// Prescaler free-runs, so one tick of slack either way
	task automatic t_prescale;
		int div [7];
		int e;
		div = '{1, 8, 32, 64, 128, 256, 1024};
		wr(ADDR_COUNT, 8'h00);
		repeat (20) @(posedge mclk_i);
		rdc(ADDR_COUNT, 8'h00, "sel_stop");
		for (int s = 0; s < 7; s++)
		begin
			e = (8 * div[s] + 3) / div[s];
			wr(ADDR_COUNT, 8'h00);
			wr(ADDR_CONTROL_B, 8'(s + 1));
			repeat (8 * div[s]) @(posedge mclk_i);
			wr(ADDR_CONTROL_B, 8'h00);
			apb(1'b0, ADDR_COUNT, 8'h00);
			check("prescale", {31'h0, rv >= e - 1 && rv <= e + 1}, 32'h1);
		end
	endtask : t_prescale

	task automatic t_phase;
		wr(ADDR_CONTROL_A, 8'h01);
		wr(ADDR_COUNT, 8'h10);
		wr(ADDR_IRQ_FLAGS, 8'h07);
		wr(ADDR_CONTROL_B, 8'h01);
		repeat (300) @(posedge mclk_i);
		apb(1'b0, ADDR_IRQ_FLAGS, 8'h00);
		check("pwm_no_ovf_top", {31'h0, rv[0]}, 32'h0);
		repeat (250) @(posedge mclk_i);
		apb(1'b0, ADDR_IRQ_FLAGS, 8'h00);
		check("pwm_ovf_bottom", {31'h0, rv[0]}, 32'h1);
		wr(ADDR_CONTROL_B, 8'h00);
	endtask : t_phase

	// Pin clock source: one count per synchronised rising edge
	task automatic t_async;
		wr(ADDR_CONTROL_A, 8'h00);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CONFIG, 8'h01);
		wr(ADDR_CONTROL_B, 8'h01);
		repeat (5)
		begin
			tosc <= 1'b1;
			repeat (4) @(posedge mclk_i);
			tosc <= 1'b0;
			repeat (4) @(posedge mclk_i);
		end
		wr(ADDR_CONTROL_B, 8'h00);
		wr(ADDR_CONFIG, 8'h00);
		rdc(ADDR_COUNT, 8'h05, "async_ticks");
	endtask : t_async

	// Clear-on-match keeps the count at or below compare A
	task automatic t_ctc;
		wr(ADDR_CONTROL_A, 8'h02);
		wr(ADDR_CMP_A, 8'h05);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CONTROL_B, 8'h01);
		repeat (40) @(posedge mclk_i);
		wr(ADDR_CONTROL_B, 8'h00);
		apb(1'b0, ADDR_COUNT, 8'h00);
		check("ctc_top", {31'h0, rv <= 8'h05}, 32'h1);
		wr(ADDR_CONTROL_A, 8'h00);
	endtask : t_ctc

	// ----------------------------------------------------------------
	// Closing report, hang guard and main sequence
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// Whole run needs about 13300 cycles; the ceiling leaves margin
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_errors++;
			test_done();
		end
	end

	initial
	begin
		req = '0;
		ack = 3'b000;
		tosc = 1'b0;
		reset_n_i = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_force();
		t_match();
		t_overflow();
		t_prescale();
		t_phase();
		t_async();
		t_ctc();
		test_done();
	end

endmodule : tb_top
